// File: hdl/serial_shift_transceiver.sv
// serial shift transceiver: register slave, clock generator, shift engine, pin mux
// assumes an AXI4-Lite master on I_SYS_CLK and three shared pins from outside
`timescale 1ns/1ps
`default_nettype none
`include "sst_regs.svh"

module serial_shift_transceiver
  import sst_pkg::*;
#(
  parameter int ADDR_W = 12
) (
  input  wire logic              I_SYS_CLK,
  input  wire logic              I_RESET_N,
  input  wire logic [ADDR_W-1:0] I_AWADDR,
  input  wire logic              I_AWVALID,
  output logic                   O_AWREADY,
  input  wire logic [31:0]       I_WDATA,
  input  wire logic [3:0]        I_WSTRB,
  input  wire logic              I_WVALID,
  output logic                   O_WREADY,
  output logic [1:0]             O_BRESP,
  output logic                   O_BVALID,
  input  wire logic              I_BREADY,
  input  wire logic [ADDR_W-1:0] I_ARADDR,
  input  wire logic              I_ARVALID,
  output logic                   O_ARREADY,
  output logic [31:0]            O_RDATA,
  output logic [1:0]             O_RRESP,
  output logic                   O_RVALID,
  input  wire logic              I_RREADY,
  input  wire logic [2:0]        I_PIN_IN,
  output logic [2:0]             O_PIN_OUT,
  output logic [2:0]             O_PIN_OE,
  output logic                   O_IRQ
);

  function automatic logic is_mapped(input logic [ADDR_W-1:0] a);
    logic [7:0] i;
    i = a[9:2];
    return (a[ADDR_W-1:10] == '0) && (i >= `SST_IDX_MODE) && (i <= `SST_IDX_PIN);
  endfunction

  function automatic logic [4:0] rate_last(input logic [1:0] r);
    case (r)
      `SST_RATE_DIV32: return `SST_DIV32_LAST;
      `SST_RATE_DIV16: return `SST_DIV16_LAST;
      default:         return `SST_DIV8_LAST;
    endcase
  endfunction

  function automatic logic pick_bit(input logic [7:0] b, input logic [2:0] n,
                                    input logic lsb);
    return lsb ? b[n] : b[3'h7 - n];
  endfunction

  logic [7:0]  mode_q, reload_q, buf_q, cnt_q, rx_q, rx_d;
  logic        done_q, irq_en_q, irq_q;
  logic [2:0]  pdir_q, pod_q, pdata_q;
  logic [2:0]  pin_s1_q, pin_s2_q, pin_s3_q, pin_f_q;
  logic        sck_prev_q, sck_lvl_q, so_bit;
  logic [4:0]  pre_q;
  logic [3:0]  edge_q;
  logic [2:0]  tx_idx_q;
  xfer_state_t state_q;
  logic        aw_held_q, w_held_q, bvalid_q, rvalid_q, wstrb0_q;
  logic [ADDR_W-1:0] awaddr_q;
  logic [7:0]  wdata_q;
  logic [1:0]  bresp_q, rresp_q;
  logic [31:0] rdata_q, rd_word;
  logic        wr_fire, wr_go, go, busy_m, base_tick, toggle, edge_ev;
  logic        sample, shift_out, done_ev;
  logic [7:0]  wr_idx;
  logic [2:0]  drv_out, drv_oe, pin_out_q, pin_oe_q;

  wire en        = mode_q[`SST_MODE_EN];
  wire start     = mode_q[`SST_MODE_START];
  wire [1:0] rate = mode_q[`SST_MODE_RATE_HI:`SST_MODE_RATE_LO];
  wire lsb_first = mode_q[`SST_MODE_ORDER];
  wire slave     = mode_q[`SST_MODE_CLKSRC];
  wire clock_idle_polarity      = mode_q[`SST_MODE_CLOCK_IDLE_POLARITY];
  wire clock_sample_phase      = mode_q[`SST_MODE_CLOCK_SAMPLE_PHASE];

  default clocking cb @(posedge I_SYS_CLK); endclocking
  default disable iff (!I_RESET_N);

  ////////////////////////////////////////////////////////////////////////////
  // register bus slave

  assign O_AWREADY = !aw_held_q;
  assign O_WREADY  = !w_held_q;
  assign O_BVALID  = bvalid_q;
  assign O_BRESP   = bresp_q;
  assign O_ARREADY = !rvalid_q;
  assign O_RVALID  = rvalid_q;
  assign O_RDATA   = rdata_q;
  assign O_RRESP   = rresp_q;
  assign wr_fire   = aw_held_q && w_held_q && !bvalid_q;
  assign wr_idx    = awaddr_q[9:2];
  // only the low byte lane carries register bits
  assign wr_go     = wr_fire && wstrb0_q && is_mapped(awaddr_q);

  always_ff @(posedge I_SYS_CLK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      aw_held_q <= 1'b0;
      w_held_q  <= 1'b0;
      awaddr_q  <= '0;
      wdata_q   <= `SST_RST_BYTE;
      wstrb0_q  <= 1'b0;
      bvalid_q  <= 1'b0;
      bresp_q   <= `SST_RESP_OKAY;
    end else begin
      if (I_AWVALID && !aw_held_q) begin
        aw_held_q <= 1'b1;
        awaddr_q  <= I_AWADDR;
      end
      if (I_WVALID && !w_held_q) begin
        w_held_q <= 1'b1;
        wdata_q  <= I_WDATA[7:0];
        wstrb0_q <= I_WSTRB[0];
      end
      if (wr_fire) begin
        aw_held_q <= 1'b0;
        w_held_q  <= 1'b0;
        bvalid_q  <= 1'b1;
        bresp_q   <= is_mapped(awaddr_q) ? `SST_RESP_OKAY : `SST_RESP_SLVERR;
      end else if (bvalid_q && I_BREADY) begin
        bvalid_q <= 1'b0;
      end
    end
  end

  always_comb begin
    rd_word = '0;
    case (I_ARADDR[9:2])
      `SST_IDX_MODE:   rd_word[7:0] = mode_q;
      `SST_IDX_BUF:    rd_word[7:0] = buf_q;
      `SST_IDX_STATUS: rd_word[`SST_STAT_IRQEN:`SST_STAT_DONE] = {irq_en_q, done_q};
      `SST_IDX_PDIR:   rd_word[2:0] = pdir_q;
      `SST_IDX_POD:    rd_word[2:0] = pod_q;
      `SST_IDX_PDATA:  rd_word[2:0] = pdata_q;
      `SST_IDX_PIN:    rd_word[2:0] = pin_f_q;
      default:         rd_word = '0;
    endcase
  end

  always_ff @(posedge I_SYS_CLK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      rvalid_q <= 1'b0;
      rdata_q  <= '0;
      rresp_q  <= `SST_RESP_OKAY;
    end else if (I_ARVALID && !rvalid_q) begin
      rvalid_q <= 1'b1;
      rdata_q  <= is_mapped(I_ARADDR) ? rd_word : '0;
      rresp_q  <= is_mapped(I_ARADDR) ? `SST_RESP_OKAY : `SST_RESP_SLVERR;
    end else if (rvalid_q && I_RREADY) begin
      rvalid_q <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // software registers

  always_ff @(posedge I_SYS_CLK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      mode_q <= `SST_RST_BYTE;
    end else if (wr_go && wr_idx == `SST_IDX_MODE) begin
      mode_q <= wdata_q;
    // RQ9 start self-clears
    end else if (done_ev) begin
      mode_q[`SST_MODE_START] <= 1'b0;
    end
  end

  always_ff @(posedge I_SYS_CLK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      reload_q <= `SST_RST_BYTE;
      irq_en_q <= 1'b0;
      pdir_q   <= `SST_RST_PINS;
      pod_q    <= `SST_RST_PINS;
      pdata_q  <= `SST_RST_PINS;
    end else if (wr_go) begin
      if (wr_idx == `SST_IDX_RELOAD) reload_q <= wdata_q;
      if (wr_idx == `SST_IDX_STATUS) irq_en_q <= wdata_q[`SST_STAT_IRQEN];
      if (wr_idx == `SST_IDX_PDIR)   pdir_q   <= wdata_q[2:0];
      if (wr_idx == `SST_IDX_POD)    pod_q    <= wdata_q[2:0];
      if (wr_idx == `SST_IDX_PDATA)  pdata_q  <= wdata_q[2:0];
    end
  end

  // RQ9 sticky done flag; a completion beats a clearing write
  always_ff @(posedge I_SYS_CLK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      done_q <= 1'b0;
    end else if (done_ev) begin
      done_q <= 1'b1;
    end else if (wr_go && wr_idx == `SST_IDX_STATUS && !wdata_q[`SST_STAT_DONE]) begin
      done_q <= 1'b0;
    end
  end

  property p_done_end;
    done_ev |=> done_q && !start && state_q == ST_IDLE;
  endproperty
  a_done_end: assert property (p_done_end) // RQ9
    else $error("completion did not set flag and clear start");

  // RQ11 interrupt request
  always_ff @(posedge I_SYS_CLK or negedge I_RESET_N) begin
    if (!I_RESET_N) irq_q <= 1'b0;
    else            irq_q <= done_q && irq_en_q;
  end
  assign O_IRQ = irq_q;
  property p_irq;
    done_q && irq_en_q |=> O_IRQ;
  endproperty
  a_irq: assert property (p_irq) // RQ11
    else $error("interrupt not raised");

  ////////////////////////////////////////////////////////////////////////////
  // pin input synchroniser: a change counts once stages two and three agree

  always_ff @(posedge I_SYS_CLK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      pin_s1_q   <= `SST_RST_PINS;
      pin_s2_q   <= `SST_RST_PINS;
      pin_s3_q   <= `SST_RST_PINS;
      pin_f_q    <= `SST_RST_PINS;
      sck_prev_q <= 1'b0;
    end else begin
      pin_s1_q   <= I_PIN_IN;
      pin_s2_q   <= pin_s1_q;
      pin_s3_q   <= pin_s2_q;
      pin_f_q    <= ((pin_s2_q ~^ pin_s3_q) & pin_s3_q) | ((pin_s2_q ^ pin_s3_q) & pin_f_q);
      sck_prev_q <= pin_f_q[`SST_PIN_SCK];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // master clock generation

  // RQ17 start acts whenever enable is set, even when both arrive in the same write
  assign go        = en && start && state_q == ST_IDLE;
  assign busy_m    = !slave && state_q != ST_IDLE;
  // RQ2 rate base select
  assign base_tick = busy_m && (rate == `SST_RATE_FULL || pre_q == rate_last(rate));
  // RQ20 one toggle per overflow
  assign toggle    = base_tick && cnt_q == `SST_CNT_TOP;

  always_ff @(posedge I_SYS_CLK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      pre_q <= '0;
    end else if (go || base_tick) begin
      pre_q <= '0;
    end else if (busy_m) begin
      pre_q <= pre_q + 5'h01;
    end
  end

  // RQ3 post-scaler with auto reload
  always_ff @(posedge I_SYS_CLK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      cnt_q <= `SST_RST_BYTE;
    end else if (go || toggle) begin
      cnt_q <= reload_q;
    end else if (base_tick) begin
      cnt_q <= cnt_q + 8'h01;
    end
  end

  property p_reload;
    toggle && !go |=> cnt_q == $past(reload_q);
  endproperty
  a_reload: assert property (p_reload) // RQ3
    else $error("counter did not reload");

  // RQ4 idle level, RQ19 master drives clock
  always_ff @(posedge I_SYS_CLK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      sck_lvl_q <= 1'b0;
    end else if (state_q == ST_IDLE) begin
      sck_lvl_q <= clock_idle_polarity;
    end else if (busy_m && edge_ev) begin
      sck_lvl_q <= !sck_lvl_q;
    end
  end
  property p_idle_level;
    state_q == ST_IDLE && $past(state_q) == ST_IDLE |-> sck_lvl_q == $past(clock_idle_polarity);
  endproperty
  a_idle_level: assert property (p_idle_level) // RQ4
    else $error("idle clock level wrong");

  ////////////////////////////////////////////////////////////////////////////
  // shift engine

  // RQ1 edges from own clock as master, from the pin as slave
  assign edge_ev   = state_q == ST_SHIFT &&
                     (slave ? (pin_f_q[`SST_PIN_SCK] != sck_prev_q) : toggle);
  // RQ5 phase picks the capture edge
  assign sample    = edge_ev && (edge_q[0] == clock_sample_phase);
  // RQ6 output moves on the other edge
  assign shift_out = edge_ev && !sample && edge_q != 4'h0;
  // RQ10 master ends half a clock later; a slave has no clock to wait on
  assign done_ev   = (state_q == ST_TAIL && toggle) ||
                     (slave && edge_ev && edge_q == `SST_LAST_EDGE);
  // a flag left standing from an earlier byte is legal, so only a new rise is wrong
  property p_tail_wait;
    !slave && state_q == ST_SHIFT && edge_ev && edge_q == `SST_LAST_EDGE
      |=> state_q == ST_TAIL && !$rose(done_q);
  endproperty
  a_tail_wait: assert property (p_tail_wait) // RQ10
    else $error("master done without half clock wait");

  // RQ7 bit order for receive
  always_comb begin
    rx_d = rx_q;
    if (sample) begin
      rx_d = lsb_first ? {pin_f_q[`SST_PIN_SI], rx_q[7:1]}
                       : {rx_q[6:0], pin_f_q[`SST_PIN_SI]};
    end
  end

  // RQ8 exactly sixteen edges, eight bits
  always_ff @(posedge I_SYS_CLK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      state_q <= ST_IDLE;
    end else if (!en) begin
      state_q <= ST_IDLE;
    end else begin
      case (state_q)
        ST_IDLE:  if (go) state_q <= ST_SHIFT;
        ST_SHIFT: if (edge_ev && edge_q == `SST_LAST_EDGE) state_q <= slave ? ST_IDLE : ST_TAIL;
        ST_TAIL:  if (toggle) state_q <= ST_IDLE;
        default:  state_q <= ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge I_SYS_CLK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      edge_q   <= '0;
      tx_idx_q <= '0;
      rx_q     <= `SST_RST_BYTE;
    end else if (go) begin
      edge_q   <= '0;
      tx_idx_q <= '0;
    end else begin
      if (edge_ev)   edge_q   <= edge_q + 4'h1;
      if (shift_out) tx_idx_q <= tx_idx_q + 3'h1;
      rx_q <= rx_d;
    end
  end

  // RQ12 received byte lands in the shift buffer at completion
  always_ff @(posedge I_SYS_CLK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      buf_q <= `SST_RST_BYTE;
    end else if (done_ev) begin
      buf_q <= rx_d;
    end else if (wr_go && wr_idx == `SST_IDX_BUF) begin
      buf_q <= wdata_q;
    end
  end

  property p_copy;
    done_ev |=> buf_q == $past(rx_d);
  endproperty
  a_copy: assert property (p_copy) // RQ12
    else $error("received byte not copied");

  // RQ7 bit order for transmit; RQ5 first bit stands before first edge
  assign so_bit = pick_bit(buf_q, tx_idx_q, lsb_first);

  ////////////////////////////////////////////////////////////////////////////
  // shared pin mux; the serial input direction stays with software

  // RQ14 pins general purpose unless enabled; RQ15 forced directions
  always_comb begin
    drv_oe  = pdir_q;
    drv_out = pdata_q;
    if (en) begin
      drv_oe[`SST_PIN_SCK]  = !slave;
      drv_out[`SST_PIN_SCK] = sck_lvl_q;
      drv_oe[`SST_PIN_SO]   = 1'b1;
      drv_out[`SST_PIN_SO]  = so_bit;
    end
  end

  // RQ18 open-drain pins only pull low
  always_ff @(posedge I_SYS_CLK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      pin_out_q <= `SST_RST_PINS;
      pin_oe_q  <= `SST_RST_PINS;
    end else begin
      pin_out_q <= drv_out & ~pod_q;
      pin_oe_q  <= drv_oe & ~(pod_q & drv_out);
    end
  end
  assign O_PIN_OUT = pin_out_q;
  assign O_PIN_OE  = pin_oe_q;
  property p_master_drives_clk;
    en && !slave && !pod_q[`SST_PIN_SCK] |=> O_PIN_OE[`SST_PIN_SCK];
  endproperty
  a_master_drives_clk: assert property (p_master_drives_clk) // RQ1
    else $error("master clock pin not driven");
  property p_slave_clk_input;
    en && slave |=> !O_PIN_OE[`SST_PIN_SCK];
  endproperty
  a_slave_clk_input: assert property (p_slave_clk_input) // RQ15
    else $error("slave clock pin driven");
  property p_gpio_dir;
    !en && pod_q == `SST_RST_PINS |=> O_PIN_OE == $past(pdir_q);
  endproperty
  a_gpio_dir: assert property (p_gpio_dir) // RQ14
    else $error("disabled pins ignore direction register");

endmodule // serial_shift_transceiver
`default_nettype wire

// File: hdl/sst_pkg.sv
// types shared by the serial shift transceiver
// assumes sst_regs.svh supplies all numeric constants
package sst_pkg;
  typedef enum logic [1:0] {ST_IDLE, ST_SHIFT, ST_TAIL} xfer_state_t;
endpackage

// File: hdl/sst_regs.svh
// register map, field positions and counts of the serial shift transceiver
// assumes the 32-bit register bus word index is the byte address divided by four
// Summary of operation
// RQ1: clock source select 0 makes us master driving clock; 1 makes us slave.
// RQ2: master rate select: 00 base clock, 01 /32, 10 /16, 11 /8; slave ignores it.
// RQ3: eight-bit counter on rate base reloads from write-only reload register at end.
// RQ4: idle polarity bit holds serial clock low (0) or high (1) between transfers.
// RQ5: phase 0 presents first bit before first edge; phase 1 captures on second edge.
// RQ6: bits move on the transfer edge; serial output changes on the opposite edge.
// RQ7: bit order 0 shifts most significant bit first, 1 least significant first.
// RQ8: with enable and start set, exactly eight bits shift, then logic stops.
// RQ9: end of byte sets sticky done flag and clears start; software clears flag.
// RQ10: done flag and start clear appear half a serial clock after last bit; as slave the code sets them on the last edge.
// RQ11: with transfer interrupt enable set, completion raises the interrupt request.
// RQ12: received bits collect separately and are copied to shift buffer at completion.
// RQ13: software writes no transmit byte mid-shift and reads each byte in time.
// RQ14: enable 0 leaves three shared pins general purpose; 1 makes them serial pins.
// RQ15: enabled: clock pin input as slave, output as master; serial output always driven.
// RQ16: software sets the serial input pin to input in the direction register.
// RQ17: software sets enable, polarity and phase before setting start, not together.
// RQ18: each serial pin can be push-pull or open-drain per open-drain register.
// RQ19: master starts by clocking; both ends share mode and swap one byte each.
// RQ20: clock toggles on each counter overflow from 255: half period 256 minus reload.
`ifndef SST_REGS_SVH
`define SST_REGS_SVH

// register indices; byte address is four times the index
`define SST_IDX_MODE     8'hb4
`define SST_IDX_RELOAD   8'hb5
`define SST_IDX_BUF      8'hb6
`define SST_IDX_STATUS   8'hb7
`define SST_IDX_PDIR     8'hb8
`define SST_IDX_POD      8'hb9
`define SST_IDX_PDATA    8'hba
`define SST_IDX_PIN      8'hbb

// serial_mode_control fields
`define SST_MODE_EN      7
`define SST_MODE_START   6
`define SST_MODE_RATE_HI 5
`define SST_MODE_RATE_LO 4
`define SST_MODE_ORDER   3
`define SST_MODE_CLKSRC  2
`define SST_MODE_CLOCK_IDLE_POLARITY    1
`define SST_MODE_CLOCK_SAMPLE_PHASE    0

// status register fields
`define SST_STAT_DONE    0
`define SST_STAT_IRQEN   1

// shared pin positions
`define SST_PIN_SCK      0
`define SST_PIN_SI       1
`define SST_PIN_SO       2

`define SST_RST_BYTE     8'h00
`define SST_RST_PINS     3'h0
`define SST_RATE_FULL    2'h0
`define SST_RATE_DIV32   2'h1
`define SST_RATE_DIV16   2'h2
`define SST_DIV32_LAST   5'h1f
`define SST_DIV16_LAST   5'h0f
`define SST_DIV8_LAST    5'h07
`define SST_CNT_TOP      8'hff
`define SST_LAST_EDGE    4'hf
`define SST_RESP_OKAY    2'h0
`define SST_RESP_SLVERR  2'h2

`endif

// File: test/serial_shift_transceiver_tb_top.sv
// self-checking bench: register bus master, pin resolution, far-end model
// assumes pull-ups on the clock and serial output pins and default ADDR_W of 12
`timescale 1ns/1ps
`default_nettype none
`include "sst_regs.svh"

`define CHK(g, e) begin checks++; if ((g) !== (e)) begin num_errors++; \
  $display("[ERR] %0t got %h exp %h", $time, (g), (e)); end end

module serial_shift_transceiver_tb_top;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic [11:0] awaddr = '0, araddr = '0;
  logic [31:0] wdata = '0;
  logic        awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0, m_load = 0;
  logic [7:0]  mcfg = '0;
  logic [7:0]  mtx_q = '0;
  wire logic   awready, wready, bvalid, arready, rvalid, irq, m_sck, m_sck_oe, m_si;
  wire logic [1:0]  bresp, rresp;
  wire logic [31:0] rdata;
  wire logic [2:0]  pout, oe, pin;
  wire logic [7:0]  m_rx;
  logic [31:0] rdat;
  logic [1:0]  resp;
  logic        sck_d = 1'b1;
  int          edges = 0, gap = 0, since = 0, checks = 0, num_errors = 0;

  always #2 clk = ~clk;

  assign pin[0] = oe[0] ? pout[0] : (m_sck_oe ? m_sck : 1'b1);
  assign pin[1] = oe[1] ? pout[1] : m_si;
  assign pin[2] = oe[2] ? pout[2] : 1'b1;

  serial_shift_transceiver i_dut (
    .I_SYS_CLK(clk), .I_RESET_N(rst_n), .I_AWADDR(awaddr), .I_AWVALID(awvalid),
    .O_AWREADY(awready), .I_WDATA(wdata), .I_WSTRB(4'hf), .I_WVALID(wvalid),
    .O_WREADY(wready), .O_BRESP(bresp), .O_BVALID(bvalid), .I_BREADY(bready),
    .I_ARADDR(araddr), .I_ARVALID(arvalid), .O_ARREADY(arready), .O_RDATA(rdata),
    .O_RRESP(rresp), .O_RVALID(rvalid), .I_RREADY(rready), .I_PIN_IN(pin),
    .O_PIN_OUT(pout), .O_PIN_OE(oe), .O_IRQ(irq));

  sst_far_end i_far (
    .i_clk(clk), .i_load(m_load), .i_drive(mcfg[2]), .i_clock_idle_polarity(mcfg[1]), .i_clock_sample_phase(mcfg[0]),
    .i_lsb(mcfg[3]), .i_tx(8'h00 ^ mtx_q), .i_sck(pin[0]), .i_so(pin[2]), .o_sck(m_sck),
    .o_sck_oe(m_sck_oe), .o_si(m_si), .o_rx(m_rx));

  // edge spacing of the serial clock pin
  always @(posedge clk) begin
    sck_d <= pin[0];
    if (pin[0] !== sck_d) begin
      edges <= edges + 1;
      gap   <= since + 1;
      since <= 0;
    end else begin
      since <= since + 1;
    end
  end

  ////////////////////////////////////////
  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    int t;
    t = 0;
    @(posedge clk);
    awaddr  <= {2'b00, idx, 2'b00};
    wdata   <= {24'h0, d};
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    do begin
      @(posedge clk);
      t++;
      if (awvalid && awready === 1'b1) awvalid <= 1'b0;
      if (wvalid && wready === 1'b1) wvalid <= 1'b0;
    end while (bvalid !== 1'b1 && t < 500);
    resp = bresp;
    bready <= 1'b0;
    if (t >= 500) num_errors++;
  endtask

  task automatic rd(input logic [7:0] idx);
    int t;
    t = 0;
    @(posedge clk);
    araddr  <= {2'b00, idx, 2'b00};
    arvalid <= 1'b1;
    rready  <= 1'b1;
    do begin
      @(posedge clk);
      t++;
      if (arvalid && arready === 1'b1) arvalid <= 1'b0;
    end while (rvalid !== 1'b1 && t < 500);
    rdat = rdata;
    resp = rresp;
    rready <= 1'b0;
    if (t >= 500) num_errors++;
  endtask

  ////////////////////////////////////////
  task automatic t_regs;
    for (int i = 0; i < 3; i++) begin
      rd(`SST_IDX_MODE + 8'(i));
      `CHK(rdat, 32'h0)
    end
    wr(`SST_IDX_RELOAD, 8'h5a);
    `CHK(resp, `SST_RESP_OKAY)
    rd(`SST_IDX_RELOAD);
    `CHK(rdat, 32'h0)
    rd(8'hbc);
    `CHK(resp, `SST_RESP_SLVERR)
    wr(8'h10, 8'hff);
    `CHK(resp, `SST_RESP_SLVERR)
    $display("t_regs done");
  endtask

  task automatic t_gpio;
    wr(`SST_IDX_PDATA, 8'h05);
    wr(`SST_IDX_PDIR, 8'h07);
    repeat (3) @(posedge clk);
    `CHK(oe, 3'b111)
    `CHK(pout, 3'b101)
    wr(`SST_IDX_POD, 8'h07);
    repeat (3) @(posedge clk);
    `CHK(oe, 3'b010)
    `CHK(pout, 3'b000)
    rd(`SST_IDX_PIN);
    `CHK(rdat[2:0], 3'b101)
    wr(`SST_IDX_POD, 8'h00);
    wr(`SST_IDX_PDIR, 8'h00);
    wr(`SST_IDX_MODE, 8'h80);
    repeat (3) @(posedge clk);
    `CHK(oe, 3'b101)
    wr(`SST_IDX_MODE, 8'h00);
    wr(`SST_IDX_STATUS, 8'h02);
    wr(`SST_IDX_MODE, 8'h40);
    repeat (100) @(posedge clk);
    `CHK(irq, 1'b0)
    `CHK(oe, 3'b000)
    wr(`SST_IDX_MODE, 8'h00);
    $display("t_gpio done");
  endtask

  task automatic xfer(input logic [7:0] mode, rel, dtx, mtx, input int hp);
    int t, e0;
    mcfg  <= mode;
    mtx_q <= mtx;
    wr(`SST_IDX_RELOAD, rel);
    wr(`SST_IDX_BUF, dtx);
    wr(`SST_IDX_STATUS, 8'h02);
    wr(`SST_IDX_MODE, mode | 8'h80);
    repeat (4) @(posedge clk);
    e0 = edges;
    wr(`SST_IDX_MODE, mode | 8'hc0);
    m_load <= 1'b1;
    @(posedge clk);
    m_load <= 1'b0;
    t = 0;
    while (irq !== 1'b1 && t < 5000) begin
      @(posedge clk);
      t++;
    end
    if (t >= 5000) num_errors++;
    `CHK(edges - e0, 16)
    `CHK(pin[0], mode[1])
    `CHK(oe[0], !mode[2])
    `CHK(oe[2], 1'b1)
    if (!mode[2]) begin
      `CHK(gap, hp)
      `CHK(since >= hp - 2 && since <= hp + 4, 1'b1)
    end
    rd(`SST_IDX_MODE);
    `CHK(rdat, {24'h0, mode | 8'h80})
    // byte read before the next one
    rd(`SST_IDX_BUF);
    `CHK(rdat, {24'h0, mtx})
    `CHK(m_rx, dtx)
    wr(`SST_IDX_MODE, 8'h00);
  endtask

  task automatic t_modes;
    for (int k = 0; k < 8; k++) begin
      xfer({4'h0, k[2], 1'b0, k[1], k[0]}, 8'hf8, 8'h35 + 8'(k), 8'hc6 ^ 8'(k), 8);
    end
    $display("t_modes done");
  endtask

  task automatic t_rates;
    logic [7:0] rel [3] = '{8'hff, 8'hfe, 8'hfd};
    int         base [3] = '{32, 16, 8};
    for (int i = 0; i < 3; i++) begin
      xfer({2'b00, 2'(i + 1), 4'h0}, rel[i], 8'ha1, 8'h5e, (256 - int'(rel[i])) * base[i]);
    end
    $display("t_rates done");
  endtask

  task automatic t_slave;
    xfer(8'h3e, 8'h00, 8'h96, 8'h0f, 0);
    xfer(8'h05, 8'h00, 8'h4b, 8'hd2, 0);
    $display("t_slave done");
  endtask

  task automatic t_irq;
    `CHK(irq, 1'b1)
    wr(`SST_IDX_STATUS, 8'h01);
    repeat (3) @(posedge clk);
    `CHK(irq, 1'b0)
    rd(`SST_IDX_STATUS);
    `CHK(rdat, 32'h1)
    wr(`SST_IDX_STATUS, 8'h03);
    repeat (3) @(posedge clk);
    `CHK(irq, 1'b1)
    wr(`SST_IDX_STATUS, 8'h02);
    repeat (3) @(posedge clk);
    `CHK(irq, 1'b0)
    $display("t_irq done");
  endtask

  task automatic wrap_up;
    $display("checks %0d errors %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  ////////////////////////////////////////
  initial begin
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    t_regs;
    t_gpio;
    t_modes;
    t_rates;
    t_slave;
    t_irq;
    wrap_up;
  end

  // whole run is well under 20k cycles
  initial begin
    repeat (60000) @(posedge clk);
    num_errors++;
    wrap_up;
  end
endmodule // serial_shift_transceiver_tb_top

`default_nettype wire

// File: test/sst_far_end.sv
// far-end serial device: slave to our master, or clock source when we are slave
// assumes the bench resolves pin levels; everything is sampled on the system clock
`timescale 1ns/1ps
`default_nettype none

module sst_far_end #(
  parameter int HALF = 8
) (
  input  wire logic       i_clk,
  input  wire logic       i_load,
  input  wire logic       i_drive,
  input  wire logic       i_clock_idle_polarity,
  input  wire logic       i_clock_sample_phase,
  input  wire logic       i_lsb,
  input  wire logic [7:0] i_tx,
  input  wire logic       i_sck,
  input  wire logic       i_so,
  output logic            o_sck,
  output logic            o_sck_oe,
  output logic            o_si,
  output logic [7:0]      o_rx
);
  logic       busy_q = 1'b0;
  logic       prev_q = 1'b0;
  logic       lvl_q  = 1'b0;
  logic       last_q = 1'b0;
  logic [3:0] n_q    = 4'h0;
  logic [7:0] sh_q   = 8'h00;
  logic [7:0] rx_q   = 8'h00;
  int         tick_q = 0;
  logic       cur;

  ////////////////////////////////////////
  // bit order shared
  assign cur      = i_lsb ? sh_q[0] : sh_q[7];
  assign o_sck    = busy_q ? lvl_q : i_clock_idle_polarity;
  assign o_sck_oe = i_drive;
  // released line shows inverse, never a stale bit
  assign o_si     = busy_q ? cur : ~last_q;
  assign o_rx     = rx_q;

  ////////////////////////////////////////
  always @(posedge i_clk) begin
    prev_q <= i_sck;
    if (i_load) begin
      busy_q <= 1'b1;
      sh_q   <= i_tx;
      n_q    <= 4'h0;
      tick_q <= 0;
      lvl_q  <= i_clock_idle_polarity;
    end else if (busy_q) begin
      last_q <= cur;
      if (i_drive) begin
        tick_q <= tick_q + 1;
        if (tick_q == HALF - 1) begin
          tick_q <= 0;
          lvl_q  <= ~lvl_q;
        end
      end
      if (i_sck !== prev_q) begin
        n_q <= n_q + 4'h1;
        if (n_q == 4'hf) begin
          busy_q <= 1'b0;
        end
        if (n_q[0] == i_clock_sample_phase) begin
          rx_q <= i_lsb ? {i_so, rx_q[7:1]} : {rx_q[6:0], i_so};
        end else if (n_q != 4'h0) begin
          sh_q <= i_lsb ? (sh_q >> 1) : (sh_q << 1);
        end
      end
    end
  end
endmodule // sst_far_end

`default_nettype wire
